// ===== bench/parallel_gpio_upper_bank_bench.sv
// Self-checking bench for the upper parallel I/O pin bank
`define CHK(g, e) \
   begin \
      cmp_count++; \
      if ((g) !== (e)) \
      begin \
         err_count++; \
         $display("[ERR] %0t got %h exp %h", $time, (g), (e)); \
      end \
   end
module parallel_gpio_upper_bank_bench
   import pgb_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   // Byte addresses, four times the register index
   localparam logic [ADDR_W-1:0] A_EN = {IDX_EN, 2'b00};
   localparam logic [ADDR_W-1:0] A_DIR = {IDX_DIR, 2'b00};
   localparam logic [ADDR_W-1:0] A_VAL = {IDX_VAL, 2'b00};
   localparam logic [ADDR_W-1:0] A_BAD = A_VAL + 18'h00004; // Unmapped
   // One case: config, data, board level, expected read, enables, wires
   typedef struct packed {
      logic [15:0] cfg;
      logic [15:0] val;
      logic [13:0] ext;
      logic [31:0] rd;
      logic [13:0] oe;
      logic [13:0] pin;
   } pgb_row_t;
   pgb_row_t rows [5] = '{
      '{16'h0000, 16'h0000, 14'h1555, 32'h00001555, 14'h0000, 14'h1555},
      '{16'h3fff, 16'h2a3c, 14'h1555, 32'h00002a3c, 14'h3fff, 14'h2a3c},
      '{16'h2001, 16'h2001, 14'h0000, 32'h00002001, 14'h2001, 14'h2001},
      '{16'hc000, 16'h3fff, 14'h0aaa, 32'h00000aaa, 14'h0000, 14'h0aaa},
      '{16'h1ffe, 16'h0000, 14'h3fff, 32'h00002001, 14'h1ffe, 14'h2001}};
   logic mclk, rst_n, awvalid, wvalid, bready, arvalid, rready; // Bus side
   logic [ADDR_W-1:0] awaddr, araddr;     // Addresses
   logic [DATA_W-1:0] wdata, rdata;       // Data
   logic [3:0] wstrb;                     // Strobes
   logic awready, wready, bvalid, arready, rvalid; // Slave handshakes
   logic [1:0] bresp, rresp;              // Responses
   logic [PIN_N-1:0] pin_lvl, pin_drv, pin_oe, ext; // Pin side
   logic [1:0] rr;                        // Last response
   logic [31:0] rd;                       // Last read data
   int err_count;                         // Mismatches
   int cmp_count;                         // Comparisons
   // Device under test
   pgb_gpio_hi i_pgb_gpio_hi (
      .mclk_i(mclk), .rst_n_i(rst_n),
      .awaddr_i(awaddr), .awprot_i(3'h0), .awvalid_i(awvalid),
      .awready_o(awready), .wdata_i(wdata), .wstrb_i(wstrb),
      .wvalid_i(wvalid), .wready_o(wready), .bresp_o(bresp),
      .bvalid_o(bvalid), .bready_i(bready), .araddr_i(araddr),
      .arprot_i(3'h0), .arvalid_i(arvalid), .arready_o(arready),
      .rdata_o(rdata), .rresp_o(rresp), .rvalid_o(rvalid),
      .rready_i(rready), .pin_i(pin_lvl), .pin_o(pin_drv),
      .pin_oe_o(pin_oe));
   // Board signals on the pins
   pgb_board i_pgb_board (
      .pin_drv_i(pin_drv), .pin_oe_i(pin_oe), .ext_i(ext), .lvl_o(pin_lvl));
   // Clock, 40 ns period
   initial
   begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   // Verdict and end of run
   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : tally_and_finish
   // Bus write; address and data offered together, response awaited
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d,
                     output logic [1:0] r, input logic [3:0] s = 4'h3);
      logic got;
      r = 2'h3;
      got = 1'b0;
      @(posedge mclk);
      awaddr <= a;
      wdata <= {16'h0000, d};
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!got)
      begin
         @(posedge mclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready)
         begin
            r = bresp;
            bready <= 1'b0;
            got = 1'b1;
         end
      end
   endtask : wr
   // Bus read; data and response taken at the rvalid edge
   task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [31:0] d,
                         output logic [1:0] r);
      logic got;
      r = 2'h3;
      d = 'x;
      got = 1'b0;
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!got)
      begin
         @(posedge mclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready)
         begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            got = 1'b1;
         end
      end
   endtask : rd_reg
   // Main sequence
   initial
   begin
      err_count = 0;
      cmp_count = 0;
      rst_n = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      wstrb = 4'h0;
      ext = 14'h2a5c;
      repeat (8) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      `CHK(pin_oe, 14'h0000)
      rd_reg(A_EN, rd, rr);
      `CHK(rd, 32'h00000000)
      rd_reg(A_DIR, rd, rr);
      `CHK(rd, 32'h00000000)
      rd_reg(A_VAL, rd, rr);
      `CHK(rd, 32'h00002a5c)
      // Table cases; enable and direction always written equal
      foreach (rows[i])
      begin
         ext <= rows[i].ext;
         wr(A_EN, rows[i].cfg, rr);
         wr(A_DIR, rows[i].cfg, rr);
         wr(A_VAL, rows[i].val, rr);
         repeat (4) @(posedge mclk);
         rd_reg(A_EN, rd, rr);
         `CHK(rd, {16'h0000, rows[i].cfg})
         rd_reg(A_DIR, rd, rr);
         `CHK(rd, {16'h0000, rows[i].cfg})
         rd_reg(A_VAL, rd, rr);
         `CHK(rd, rows[i].rd)
         `CHK(rr, RESP_OKAY)
         `CHK(pin_oe, rows[i].oe)
         `CHK(pin_lvl, rows[i].pin)
      end
      // Unmapped place: error answer, nothing changes
      wr(A_BAD, 16'h3fff, rr);
      `CHK(rr, RESP_SLVERR)
      rd_reg(A_BAD, rd, rr);
      `CHK(rr, RESP_SLVERR)
      `CHK(rd, 32'h00000000)
      rd_reg(A_EN, rd, rr);
      `CHK(rd, 32'h00001ffe)
      // High byte strobe only: low byte of both registers kept
      wr(A_EN, 16'h0000, rr, 4'h2);
      `CHK(rr, RESP_OKAY)
      wr(A_DIR, 16'h0000, rr, 4'h2);
      rd_reg(A_EN, rd, rr);
      `CHK(rd, 32'h000000fe)
      rd_reg(A_VAL, rd, rr);
      `CHK(rd, 32'h00003f01)
      `CHK(pin_oe, 14'h00fe)
      `CHK(pin_lvl, 14'h3f01)
      // Second reset with outputs on
      rst_n <= 1'b0;
      repeat (8) @(posedge mclk);
      `CHK(pin_oe, 14'h0000)
      rst_n <= 1'b1;
      @(posedge mclk);
      rd_reg(A_DIR, rd, rr);
      `CHK(rd, 32'h00000000)
      rd_reg(A_VAL, rd, rr);
      `CHK(rd, 32'h00003fff)
      tally_and_finish();
   end
   // Watchdog against a hung handshake
   initial
   begin
      #100us;
      err_count++;
      $display("[ERR] %0t watchdog expired", $time);
      tally_and_finish();
   end
endmodule : parallel_gpio_upper_bank_bench

// ===== bench/pgb_board.sv
// Board model: resolves each pin wire from device drive and board level
module pgb_board
   import pgb_pkg::*;
(
   input wire logic [PIN_N-1:0] pin_drv_i,  // Device drive levels
   input wire logic [PIN_N-1:0] pin_oe_i,   // Device drive enables
   input wire logic [PIN_N-1:0] ext_i,      // Board source levels
   output logic [PIN_N-1:0] lvl_o           // Resolved wire levels
);
   timeunit 1ns;
   timeprecision 1ps;
   // Enabled pins carry the device level, others the board level
   assign lvl_o = (pin_oe_i & pin_drv_i) | (~pin_oe_i & ext_i);
endmodule : pgb_board

// ===== verilog/pgb_axil.sv
// AXI4-Lite slave front end for the pin bank registers
module pgb_axil
   import pgb_pkg::*;
(
   input wire logic mclk_i,                  // System clock
   input wire logic rst_n_i,                 // Sync reset, low
   input wire logic [ADDR_W-1:0] awaddr_i,   // Write address
   input wire logic awvalid_i,               // Write address valid
   output logic awready_o,                   // Write address ready
   input wire logic [DATA_W-1:0] wdata_i,    // Write data
   input wire logic [3:0] wstrb_i,           // Write byte strobes
   input wire logic wvalid_i,                // Write data valid
   output logic wready_o,                    // Write data ready
   output logic [1:0] bresp_o,               // Write response
   output logic bvalid_o,                    // Write response valid
   input wire logic bready_i,                // Write response ready
   input wire logic arvalid_i,               // Read address valid
   output logic arready_o,                   // Read address ready
   output logic [DATA_W-1:0] rdata_o,        // Read data
   output logic [1:0] rresp_o,               // Read response
   output logic rvalid_o,                    // Read data valid
   input wire logic rready_i,                // Read data ready
   output logic wr_fire_o,                   // Register write pulse
   output logic [ADDR_W-1:0] wr_addr_o,      // Held write address
   output logic [DATA_W-1:0] wr_data_o,      // Held write data
   output logic [3:0] wr_strb_o,             // Held strobes
   input wire logic wr_ok_i,                 // Write address mapped
   input wire logic [DATA_W-1:0] rd_data_i,  // Read data of araddr
   input wire logic rd_ok_i                  // Read address mapped
);
   logic aw_have_q; // Address held
   logic w_have_q;  // Data held
   wire aw_take = awvalid_i & awready_o;
   wire w_take = wvalid_i & wready_o;
   wire ar_take = arvalid_i & arready_o;
   wire aw_have_d = (aw_have_q | aw_take) & ~wr_fire_o;
   wire w_have_d = (w_have_q | w_take) & ~wr_fire_o;
   wire b_hold = bvalid_o & ~bready_i;
   wire r_hold_d = ar_take | (rvalid_o & ~rready_i);

   // Fire once both halves are held and the response is free
   assign wr_fire_o = aw_have_q & w_have_q & ~bvalid_o;

   // Write channels, either order
   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         awready_o <= 1'b1;
         wready_o <= 1'b1;
         bvalid_o <= 1'b0;
         bresp_o <= RESP_OKAY;
         wr_addr_o <= '0;
         wr_data_o <= '0;
         wr_strb_o <= 4'h0;
      end
      else
      begin
         aw_have_q <= aw_have_d;
         w_have_q <= w_have_d;
         awready_o <= ~aw_have_d;
         wready_o <= ~w_have_d;
         bvalid_o <= wr_fire_o | b_hold;
         if (wr_fire_o)
            bresp_o <= wr_ok_i ? RESP_OKAY : RESP_SLVERR;
         if (aw_take)
            wr_addr_o <= awaddr_i;
         if (w_take)
         begin
            wr_data_o <= wdata_i;
            wr_strb_o <= wstrb_i;
         end
      end
   end

   // Read channel, data latched as the address is taken
   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         arready_o <= 1'b1;
         rvalid_o <= 1'b0;
         rdata_o <= '0;
         rresp_o <= RESP_OKAY;
      end
      else
      begin
         arready_o <= ~r_hold_d;
         rvalid_o <= r_hold_d;
         if (ar_take)
         begin
            rdata_o <= rd_ok_i ? rd_data_i : '0;
            rresp_o <= rd_ok_i ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end
endmodule : pgb_axil

// ===== verilog/pgb_gpio_hi.sv
// Upper parallel I/O pin bank: registers, pin drive and read back
//
// Added by the designer: register access over AXI4-Lite.
module pgb_gpio_hi
   import pgb_pkg::*;
(
   input wire logic mclk_i,                 // System clock, 25 MHz
   input wire logic rst_n_i,                // Sync reset, low
   input wire logic [ADDR_W-1:0] awaddr_i,  // Write address
   input wire logic [2:0] awprot_i,         // Unused protection
   input wire logic awvalid_i,              // Write address valid
   output logic awready_o,                  // Write address ready
   input wire logic [DATA_W-1:0] wdata_i,   // Write data
   input wire logic [3:0] wstrb_i,          // Write strobes
   input wire logic wvalid_i,               // Write data valid
   output logic wready_o,                   // Write data ready
   output logic [1:0] bresp_o,              // Write response
   output logic bvalid_o,                   // Write response valid
   input wire logic bready_i,               // Write response ready
   input wire logic [ADDR_W-1:0] araddr_i,  // Read address
   input wire logic [2:0] arprot_i,         // Unused protection
   input wire logic arvalid_i,              // Read address valid
   output logic arready_o,                  // Read address ready
   output logic [DATA_W-1:0] rdata_o,       // Read data
   output logic [1:0] rresp_o,              // Read response
   output logic rvalid_o,                   // Read data valid
   input wire logic rready_i,               // Read data ready
   input wire logic [PIN_N-1:0] pin_i,      // Pin levels, bit0=pin32
   output logic [PIN_N-1:0] pin_o,          // Pin drive levels
   output logic [PIN_N-1:0] pin_oe_o        // Pin drive enables
);
   logic [REG_W-1:0] en_q;         // Output enable register
   logic [REG_W-1:0] dir_q;        // Direction register
   logic [REG_W-1:0] val_q;        // Data register
   wire [REG_W-1:0] val_d;         // Next data register, per bit
   logic [PIN_N-1:0] pin_sync;     // Synchronised pin levels
   logic wr_fire;                  // Register write pulse
   logic [ADDR_W-1:0] wr_addr;     // Held write address
   logic [DATA_W-1:0] wr_data;     // Held write data
   logic [3:0] wr_strb;            // Held strobes
   logic [DATA_W-1:0] rd_data;     // Read mux result

   // Index part of each address
   wire [15:0] wr_idx = wr_addr[ADDR_W-1:2];
   wire [15:0] rd_idx = araddr_i[ADDR_W-1:2];

   // Write decode
   wire wr_en_hit = (wr_idx == IDX_EN);
   wire wr_dir_hit = (wr_idx == IDX_DIR);
   wire wr_val_hit = (wr_idx == IDX_VAL);
   wire wr_ok = wr_en_hit | wr_dir_hit | wr_val_hit;

   // Read decode
   wire rd_en_hit = (rd_idx == IDX_EN);
   wire rd_dir_hit = (rd_idx == IDX_DIR);
   wire rd_val_hit = (rd_idx == IDX_VAL);
   wire rd_ok = rd_en_hit | rd_dir_hit | rd_val_hit;

   // Byte lane merge of the write data into a register
   function automatic logic [REG_W-1:0] merge(
      input logic [REG_W-1:0] old_v,
      input logic [DATA_W-1:0] new_v,
      input logic [3:0] strb);
      logic [REG_W-1:0] res;
      res = old_v;
      if (strb[0])
         res[7:0] = new_v[7:0];
      if (strb[1])
         res[15:8] = new_v[15:8];
      return res;
   endfunction : merge

   wire [REG_W-1:0] en_wr = merge(en_q, wr_data, wr_strb);
   wire [REG_W-1:0] dir_wr = merge(dir_q, wr_data, wr_strb);
   wire [REG_W-1:0] val_wr = merge(val_q, wr_data, wr_strb);
   wire en_we = wr_fire & wr_en_hit;
   wire dir_we = wr_fire & wr_dir_hit;
   wire val_we = wr_fire & wr_val_hit;

   // Seen value per bit: pin level for inputs, held bit for outputs
   wire [PIN_N-1:0] seen = (dir_q[PIN_N-1:0] & val_q[PIN_N-1:0])
                         | (~dir_q[PIN_N-1:0] & pin_sync);

   // Read mux; data bits map pins 32 upward by position
   assign rd_data = rd_en_hit ? {16'h0000, en_q}
                  : rd_dir_hit ? {16'h0000, dir_q}
                  : rd_val_hit ? {16'h0000, val_q[15:14], seen} // R7 R11
                  : '0;

   // Bus slave
   pgb_axil u_bus (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .awaddr_i(awaddr_i),
      .awvalid_i(awvalid_i),
      .awready_o(awready_o),
      .wdata_i(wdata_i),
      .wstrb_i(wstrb_i),
      .wvalid_i(wvalid_i),
      .wready_o(wready_o),
      .bresp_o(bresp_o),
      .bvalid_o(bvalid_o),
      .bready_i(bready_i),
      .arvalid_i(arvalid_i),
      .arready_o(arready_o),
      .rdata_o(rdata_o),
      .rresp_o(rresp_o),
      .rvalid_o(rvalid_o),
      .rready_i(rready_i),
      .wr_fire_o(wr_fire),
      .wr_addr_o(wr_addr),
      .wr_data_o(wr_data),
      .wr_strb_o(wr_strb),
      .wr_ok_i(wr_ok),
      .rd_data_i(rd_data),
      .rd_ok_i(rd_ok)
   );

   // Pin input synchroniser
   pgb_sync2 u_sync (
      .mclk_i(mclk_i),
      .async_i(pin_i),
      .sync_o(pin_sync)
   );

   // Per-bit next data value; nets, so each bit has its own driver
   generate
      for (genvar k = 0; k < PIN_N; k++)
      begin : g_val
         // Reset and inputs load the pin, outputs take writes
         assign val_d[k] = !rst_n_i ? pin_sync[k]   // R10
            : !dir_q[k] ? pin_sync[k]               // R5
            : val_we ? val_wr[k]                    // R6
            : val_q[k];
      end
   endgenerate

   // Reserved data bits
   assign val_d[RSVD_HI:RSVD_LO] = !rst_n_i ? RSVD_RST          // R12
      : val_we ? val_wr[RSVD_HI:RSVD_LO] : val_q[RSVD_HI:RSVD_LO];

   // Enable and direction registers
   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         en_q <= EN_RST;                            // R1 R12
         dir_q <= DIR_RST;                          // R5 R12
      end
      else
      begin
         if (en_we)
            en_q <= en_wr;
         if (dir_we)
            dir_q <= dir_wr;
      end
   end

   // Data register
   always_ff @(posedge mclk_i)
   begin
      val_q <= val_d;
   end

   // Pin drive from flops; reserved bits reach no pin
   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         pin_oe_o <= '0;                            // R1 R2
         pin_o <= '0;
      end
      else
      begin
         pin_oe_o <= en_q[PIN_N-1:0];               // R2 R3 R11
         pin_o <= val_q[PIN_N-1:0];                 // R8 R11
      end
   end

   // Cycle after reset: no pin driven
   AST_OE_RESET: assert property ( // R1
      @(posedge mclk_i) disable iff (!rst_n_i)
      $rose(rst_n_i) |-> pin_oe_o == '0 ##1 pin_oe_o == '0)
      else $error("pin enable not clear after reset");

   // A drive enable changes only after an enable write
   AST_OE_HOLD: assert property ( // R2
      @(posedge mclk_i) disable iff (!rst_n_i)
      !$past(en_we, 2) && !$rose(rst_n_i) && $past(rst_n_i, 2)
      |-> $stable(pin_oe_o))
      else $error("pin enable changed without a write");

   // Written enable bits reach the pins two edges later
   AST_OE_WRITE: assert property ( // R3
      @(posedge mclk_i) disable iff (!rst_n_i)
      en_we && wr_strb[1:0] == 2'h3
      |-> ##2 pin_oe_o == $past(wr_data[PIN_N-1:0], 2))
      else $error("pin enable does not follow write");

   // Direction clear after reset
   AST_DIR_RESET: assert property ( // R5
      @(posedge mclk_i) disable iff (!rst_n_i)
      $rose(rst_n_i) |-> dir_q == DIR_RST)
      else $error("direction not clear after reset");

   // Input bits read back the synchronised pin level
   AST_IN_READ: assert property ( // R7
      @(posedge mclk_i) disable iff (!rst_n_i)
      arvalid_i && arready_o && rd_val_hit
      |=> (rdata_o[PIN_N-1:0] & ~$past(dir_q[PIN_N-1:0]))
          == ($past(pin_sync) & ~$past(dir_q[PIN_N-1:0])))
      else $error("input bit read is not the pin level");

   // Written output bits are driven two edges later
   AST_OUT_WRITE: assert property ( // R6
      @(posedge mclk_i) disable iff (!rst_n_i)
      val_we && wr_strb[1:0] == 2'h3 && dir_q[PIN_N-1:0] == '1
      && !dir_we
      |-> ##2 pin_o == $past(wr_data[PIN_N-1:0], 2))
      else $error("output bit not driven from data");

   // Data bits start at the pin level
   AST_RESET_VAL: assert property ( // R10
      @(posedge mclk_i) disable iff (!rst_n_i)
      $rose(rst_n_i) |-> val_q[PIN_N-1:0] == $past(pin_sync))
      else $error("data bits did not load pin level");

   // Reserved bits clear after reset
   AST_RSVD: assert property ( // R12
      @(posedge mclk_i) disable iff (!rst_n_i)
      $rose(rst_n_i) |-> en_q[RSVD_HI:RSVD_LO] == RSVD_RST
      && dir_q[RSVD_HI:RSVD_LO] == RSVD_RST
      && val_q[RSVD_HI:RSVD_LO] == RSVD_RST)
      else $error("reserved bits not clear after reset");

   // Register and pin relations checked every cycle out of reset

   // A cleared enable field leaves every pin undriven
   AST_NO_DRIVE: assert property ( // R2
      @(posedge mclk_i) disable iff (!rst_n_i)
      en_q[PIN_N-1:0] == '0 |=> pin_oe_o == '0)
      else $error("pin driven with enable clear");

   // Each drive enable follows its enable bit one edge later
   AST_OE_FOLLOW: assert property ( // R3 R11
      @(posedge mclk_i) disable iff (!rst_n_i)
      1'b1 |=> pin_oe_o == $past(en_q[PIN_N-1:0]))
      else $error("drive enable does not follow register");

   // Enabled pins carry their data bit one edge later
   AST_OUT_LEVEL: assert property ( // R8 R11
      @(posedge mclk_i) disable iff (!rst_n_i)
      1'b1 |=> (pin_o & pin_oe_o)
         == ($past(val_q[PIN_N-1:0]) & $past(en_q[PIN_N-1:0])))
      else $error("driven level is not the data bit");

   // A full enable write lands in the register
   AST_EN_WRITE: assert property ( // R1
      @(posedge mclk_i) disable iff (!rst_n_i)
      en_we && wr_strb[1:0] == 2'h3
      |=> en_q == $past(wr_data[REG_W-1:0]))
      else $error("enable write lost");

   // A full direction write lands in the register
   AST_DIR_WRITE: assert property ( // R5 R6
      @(posedge mclk_i) disable iff (!rst_n_i)
      dir_we && wr_strb[1:0] == 2'h3
      |=> dir_q == $past(wr_data[REG_W-1:0]))
      else $error("direction write lost");

   // Without a write, enable and direction keep their value
   AST_REG_HOLD: assert property ( // R1 R5
      @(posedge mclk_i) disable iff (!rst_n_i)
      !en_we && !dir_we |=> $stable(en_q) && $stable(dir_q))
      else $error("configuration changed without a write");

   // Input data bits track the synchronised pin level
   AST_IN_TRACK: assert property ( // R5 R7
      @(posedge mclk_i) disable iff (!rst_n_i)
      1'b1 |=> (val_q[PIN_N-1:0] & ~$past(dir_q[PIN_N-1:0]))
         == ($past(pin_sync) & ~$past(dir_q[PIN_N-1:0])))
      else $error("input data bit does not track pin");

   // Output data bits hold without a data write
   AST_OUT_HOLD: assert property ( // R6
      @(posedge mclk_i) disable iff (!rst_n_i)
      !val_we |=> (val_q[PIN_N-1:0] & $past(dir_q[PIN_N-1:0]))
         == ($past(val_q[PIN_N-1:0]) & $past(dir_q[PIN_N-1:0])))
      else $error("output data bit changed without a write");

   // Reserved data bits hold without a data write
   AST_RSVD_HOLD: assert property ( // R12
      @(posedge mclk_i) disable iff (!rst_n_i)
      !val_we |=> $stable(val_q[RSVD_HI:RSVD_LO]))
      else $error("reserved data bits changed");

   // Enable read returns the whole register
   AST_RD_EN: assert property ( // R1
      @(posedge mclk_i) disable iff (!rst_n_i)
      arvalid_i && arready_o && rd_en_hit
      |=> rdata_o == {16'h0000, $past(en_q)})
      else $error("enable read wrong");

   // Direction read returns the whole register
   AST_RD_DIR: assert property ( // R5
      @(posedge mclk_i) disable iff (!rst_n_i)
      arvalid_i && arready_o && rd_dir_hit
      |=> rdata_o == {16'h0000, $past(dir_q)})
      else $error("direction read wrong");

   // Output bits read back the held data bit
   AST_RD_OUT: assert property ( // R6 R11
      @(posedge mclk_i) disable iff (!rst_n_i)
      arvalid_i && arready_o && rd_val_hit
      |=> (rdata_o[PIN_N-1:0] & $past(dir_q[PIN_N-1:0]))
         == ($past(val_q[PIN_N-1:0]) & $past(dir_q[PIN_N-1:0])))
      else $error("output bit read is not the data bit");

   // Unused protection inputs, upper write data half and upper strobes
   wire unused_ok = ^{awprot_i, arprot_i, wr_data[31:16], wr_strb[3:2]};
endmodule : pgb_gpio_hi

// ===== verilog/pgb_pkg.sv
// Constants for the upper parallel I/O pin bank
// Functional notes
// (R1) Enable field resets zero, gates pin drivers
// (R2) Enable bit zero: pin never driven
// (R3) Enable bit one: pin driver on
// (R4) Software sets direction with enable
// (R5) Direction resets zero; zero reads pin
// (R6) Direction one: data bit is driven
// (R7) Input pin reads present level
// (R8) Output pin driven to data bit
// (R9) Software keeps enable equal to direction
// (R10) Data bits reset to pin level
// (R11) Bits 0..13 map pins 32..45
// (R12) Bits 15..14 reserved, reset zero, inert
package pgb_pkg;
   localparam int PIN_N = 14;            // Pins 32..45
   localparam int PIN_BASE = 32;         // Number of pin at bit 0
   localparam int REG_W = 16;            // Register width
   localparam int ADDR_W = 18;           // Bus byte address width
   localparam int DATA_W = 32;           // Bus data width
   localparam int RSVD_HI = 15;          // Reserved field top
   localparam int RSVD_LO = 14;          // Reserved field bottom
   // Register indexes; byte address is four times the index
   localparam logic [15:0] IDX_EN = 16'h4406;
   localparam logic [15:0] IDX_DIR = 16'h4407;
   localparam logic [15:0] IDX_VAL = 16'h4408;
   // Reset values
   localparam logic [15:0] EN_RST = 16'h0000;
   localparam logic [15:0] DIR_RST = 16'h0000;
   localparam logic [1:0] RSVD_RST = 2'h0;
   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : pgb_pkg

// ===== verilog/pgb_sync2.sv
// Two-stage synchroniser for the pin inputs
module pgb_sync2
   import pgb_pkg::*;
(
   input wire logic mclk_i,               // System clock
   input wire logic [PIN_N-1:0] async_i,  // Raw pin levels
   output logic [PIN_N-1:0] sync_o        // Synchronised levels
);
   logic [PIN_N-1:0] meta_q; // First stage, read only by second

   // Data path only, no reset: levels settle in two clocks
   always_ff @(posedge mclk_i)
   begin
      meta_q <= async_i;
      sync_o <= meta_q;
   end
endmodule : pgb_sync2
